// [shared/fcr_pkg.sv]
// Constants and types of the feature control register block
package fcr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int FCR_DW        = 64;
    localparam int FCR_AW        = 8;
    localparam int FCR_LEGACY_W  = 32;
    localparam int FCR_CODE_W    = 32;
    localparam int FCR_BANK_IW   = 4;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] FCR_OFF_FC        = 8'h00;
    localparam logic [7:0] FCR_OFF_BANK_BASE = 8'h20;
    localparam logic [7:0] FCR_BANK_STRIDE   = 8'h10;
    localparam logic [7:0] FCR_BANK_STS_OFF  = 8'h08;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and write mask
    localparam logic [63:0] FCR_FC_RESET   = 64'h0000_0000_0000_0000;
    localparam logic [63:0] FCR_FC_WMASK   = 64'h0000_0000_0004_07FF;
    localparam logic [63:0] FCR_STS_RESET  = 64'h0000_0000_0000_0000;
    localparam logic        FCR_BEN_RESET  = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int FCR_B_V86   = 0;
    localparam int FCR_B_PVI   = 1;
    localparam int FCR_B_TSR   = 2;
    localparam int FCR_B_IOBP  = 3;
    localparam int FCR_B_4MPG  = 4;
    localparam int FCR_B_WIDE  = 5;
    localparam int FCR_B_MCHK  = 6;
    localparam int FCR_B_GPG   = 7;
    localparam int FCR_B_PMCU  = 8;
    localparam int FCR_B_SRS   = 9;
    localparam int FCR_B_SIMD  = 10;
    localparam int FCR_B_XST   = 18;
    localparam int FCR_STS_VLD = 63;
    localparam int FCR_STS_UNC = 62;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        FCR_PG_4K = 2'h0,
        FCR_PG_4M = 2'h1,
        FCR_PG_2M = 2'h3
    } fcr_page_t;

    typedef struct packed {
        logic        v86_mode;
        logic        prot_mode;
        logic        long_mode;
        logic        legacy_mode;
        logic [1:0]  cpl;
        logic        tsc_instr;
        logic        pmc_instr;
        logic        sse_instr;
        logic        simd_fp_exc;
        logic        dbg_acc;
        logic [2:0]  dbg_idx;
        logic        large_page_select;
        logic        tbase_write;
    } fcr_exec_t;

    typedef struct packed {
        logic                   valid;
        logic                   uncorr;
        logic [FCR_BANK_IW-1:0] bank;
        logic [FCR_CODE_W-1:0]  code;
    } fcr_err_t;

    typedef struct packed {
        logic       v86_virt_int;
        logic       tss_redirect;
        logic       sti_cli_virt;
        logic       ts_fault;
        logic       pmc_fault;
        logic       io_bp_en;
        logic       dbg_ud;
        logic       dbg_go;
        logic [2:0] dbg_idx;
        fcr_page_t  page_size;
        logic       wide_entry;
        logic       long_mode_bad;
        logic       sse_ud;
        logic       simd_ud;
        logic       simd_xf;
        logic       mc_fault;
        logic       tlb_flush;
        logic       keep_global;
    } fcr_dec_t;

endpackage

// [design/fcr_top.sv]
// Feature control register with machine check banks and decision logic
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/100ps
// Operation
// [RULE1] Legacy operation sees and writes only bits 31 to 0.
// [RULE2] Defined enable bits read and write; reserved 63-19 and 17-11 zero.
// [RULE3] Bit 0 virtualizes interrupt flag and enables redirection bitmap.
// [RULE4] Bit 1 virtualizes only set and clear interrupt; no bitmap.
// [RULE5] Bit 1 virtualization also works in long mode.
// [RULE6] Bit 2 restricts timestamp reads to privilege level 0.
// [RULE7] Bit 3 enables I/O breakpoints; debug four or five faults.
// [RULE8] Bit 3 clear: no I/O breakpoints; four, five alias six, seven.
// [RULE9] Bit 4 lets page-size flag pick 4K or 4M, else 4K.
// [RULE10] Bit 4 ignored while bit 5 set, so in long mode.
// [RULE11] Bit 5 widens table entries to 64 bits, 52-bit addresses.
// [RULE12] With bit 5 the page-size flag picks 4K or 2M.
// [RULE13] Long mode needs bit 5 set.
// [RULE14] Bit 6 raises machine-check fault on uncorrectable errors.
// [RULE15] Enabled errors are logged whatever bit 6 says.
// [RULE16] Each bank has a reporting enable and a status register.
// [RULE17] Correctable errors are logged but never fault.
// [RULE18] Bit 7 keeps global translations when table base is rewritten.
// [RULE19] Bit 8 lets any level read performance counters, else level 0.
// [RULE20] Bit 9 clear makes legacy SIMD instructions fault invalid-opcode.
// [RULE21] Bit 10 clear turns unmasked SIMD FP exceptions into invalid-opcode.
// [RULE22] Reset clears the whole feature register.
module fcr_top
    import fcr_pkg::*;
#(
    parameter int NUM_BANKS = 4
) (
    // Clock and reset
    input  wire logic              MCLK_I,
    input  wire logic              RESETN_I,
    // Register port
    input  wire logic [FCR_AW-1:0] ADDR_I,
    input  wire logic [FCR_DW-1:0] WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [FCR_DW-1:0] RDATA_O,
    // Core execution context and error reports
    input  wire fcr_exec_t         EXEC_I,
    input  wire fcr_err_t          ERR_I,
    // Decisions and register image
    output fcr_dec_t               DEC_O,
    output logic      [FCR_DW-1:0] FEATURE_O
);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [FCR_DW-1:0]                 fc;
        logic [NUM_BANKS-1:0]              bank_en;
        logic [NUM_BANKS-1:0][FCR_DW-1:0]  bank_sts;
        logic [FCR_DW-1:0]                 rdata;
        fcr_dec_t                          dec;
    } fcr_state_t;

    fcr_state_t s_q;
    fcr_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // Bank address decode, shared by read and write paths
    function automatic logic [FCR_AW-1:0] fcr_bank_addr(input int idx,
                                                        input logic sts);
        logic [FCR_AW-1:0] a;
        a = FCR_OFF_BANK_BASE + FCR_BANK_STRIDE * idx[FCR_AW-1:0];
        if (sts) begin
            a = a + FCR_BANK_STS_OFF;
        end
        return a;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [FCR_DW-1:0] wv;
        logic              f;
        logic              err_hit;
        logic              err_en;
        wv      = WDATA_I;
        f       = 1'b0;
        err_hit = 1'b0;
        err_en  = 1'b0;
        s_d     = s_q;
        s_d.rdata = '0;
        s_d.dec   = '0;

        // Feature register write; legacy keeps the upper half
        if (WR_I && ADDR_I == FCR_OFF_FC) begin
            if (EXEC_I.legacy_mode) begin
                wv[FCR_DW-1:FCR_LEGACY_W] = s_q.fc[FCR_DW-1:FCR_LEGACY_W]; // see [RULE1]
            end
            s_d.fc = wv & FCR_FC_WMASK; // see [RULE2]
        end

        // Banks: software write clears status, a new error then wins
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (WR_I && ADDR_I == fcr_bank_addr(i, 1'b0)) begin
                s_d.bank_en[i] = WDATA_I[0]; // see [RULE16]
            end
            if (WR_I && ADDR_I == fcr_bank_addr(i, 1'b1)) begin
                s_d.bank_sts[i] = FCR_STS_RESET;
            end
            if (ERR_I.valid && ERR_I.bank == i[FCR_BANK_IW-1:0]) begin
                err_hit = 1'b1;
                if (s_q.bank_en[i]) begin
                    err_en = 1'b1;
                    // Logged regardless of the fault enable
                    s_d.bank_sts[i] = '0; // see [RULE15]
                    s_d.bank_sts[i][FCR_STS_VLD] = 1'b1;
                    s_d.bank_sts[i][FCR_STS_UNC] = ERR_I.uncorr; // see [RULE17]
                    s_d.bank_sts[i][FCR_CODE_W-1:0] = ERR_I.code;
                end
            end
        end

        // Read data stand one cycle; unmapped reads give zero
        if (RD_I) begin
            if (ADDR_I == FCR_OFF_FC) begin
                s_d.rdata = s_q.fc;
                if (EXEC_I.legacy_mode) begin
                    s_d.rdata[FCR_DW-1:FCR_LEGACY_W] = '0; // see [RULE1]
                end
            end
            for (int i = 0; i < NUM_BANKS; i++) begin
                if (ADDR_I == fcr_bank_addr(i, 1'b0)) begin
                    s_d.rdata[0] = s_q.bank_en[i];
                end
                if (ADDR_I == fcr_bank_addr(i, 1'b1)) begin
                    s_d.rdata = s_q.bank_sts[i];
                end
            end
        end

        // Interrupt virtualization
        f = s_q.fc[FCR_B_V86] && EXEC_I.v86_mode;
        s_d.dec.v86_virt_int = f; // see [RULE3]
        s_d.dec.tss_redirect = f; // see [RULE4]
        // Protected mode includes long mode here
        s_d.dec.sti_cli_virt = f || (s_q.fc[FCR_B_PVI] && !EXEC_I.v86_mode
                               && (EXEC_I.prot_mode || EXEC_I.long_mode)); // see [RULE4] see [RULE5]

        // Privilege checks
        s_d.dec.ts_fault = EXEC_I.tsc_instr && s_q.fc[FCR_B_TSR]
                           && EXEC_I.cpl != 2'h0; // see [RULE6]
        s_d.dec.pmc_fault = EXEC_I.pmc_instr && !s_q.fc[FCR_B_PMCU]
                            && EXEC_I.cpl != 2'h0; // see [RULE19]

        // Debug registers four and five
        s_d.dec.io_bp_en = s_q.fc[FCR_B_IOBP]; // see [RULE7] see [RULE8]
        s_d.dec.dbg_idx  = EXEC_I.dbg_idx;
        if (EXEC_I.dbg_acc) begin
            if (EXEC_I.dbg_idx == 3'h4 || EXEC_I.dbg_idx == 3'h5) begin
                if (s_q.fc[FCR_B_IOBP]) begin
                    s_d.dec.dbg_ud = 1'b1; // see [RULE7]
                end else begin
                    s_d.dec.dbg_go  = 1'b1;
                    s_d.dec.dbg_idx = EXEC_I.dbg_idx + 3'h2; // see [RULE8]
                end
            end else begin
                s_d.dec.dbg_go = 1'b1;
            end
        end

        // Page size; wide mode overrides the 4M enable
        s_d.dec.wide_entry = s_q.fc[FCR_B_WIDE]; // see [RULE11]
        s_d.dec.page_size  = FCR_PG_4K;
        if (s_q.fc[FCR_B_WIDE]) begin
            if (EXEC_I.large_page_select) begin
                s_d.dec.page_size = FCR_PG_2M; // see [RULE10] see [RULE12]
            end
        end else if (s_q.fc[FCR_B_4MPG] && EXEC_I.large_page_select) begin
            s_d.dec.page_size = FCR_PG_4M; // see [RULE9]
        end
        s_d.dec.long_mode_bad = EXEC_I.long_mode && !s_q.fc[FCR_B_WIDE]; // see [RULE13]

        // Media instruction gating
        s_d.dec.sse_ud  = EXEC_I.sse_instr && !s_q.fc[FCR_B_SRS]; // see [RULE20]
        s_d.dec.simd_ud = EXEC_I.simd_fp_exc && !s_q.fc[FCR_B_SIMD]; // see [RULE21]
        s_d.dec.simd_xf = EXEC_I.simd_fp_exc && s_q.fc[FCR_B_SIMD];

        // Machine check fault, only enabled uncorrectable errors
        s_d.dec.mc_fault = err_hit && err_en && ERR_I.uncorr
                           && s_q.fc[FCR_B_MCHK]; // see [RULE14] see [RULE17]

        // Base rewrite flush; globals survive only when enabled
        s_d.dec.tlb_flush   = EXEC_I.tbase_write;
        s_d.dec.keep_global = EXEC_I.tbase_write && s_q.fc[FCR_B_GPG]; // see [RULE18]
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            s_q          <= '0;
            s_q.fc       <= FCR_FC_RESET; // see [RULE22]
            s_q.bank_en  <= {NUM_BANKS{FCR_BEN_RESET}};
            s_q.bank_sts <= {NUM_BANKS{FCR_STS_RESET}};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign RDATA_O   = s_q.rdata;
    assign DEC_O     = s_q.dec;
    assign FEATURE_O = s_q.fc;

endmodule // fcr_top

// [tb/fcr_top_chk.sv]
// Assertion checker for the feature control register ports
`timescale 1ns/100ps
module fcr_top_chk
    import fcr_pkg::*;
#(
    parameter int NUM_BANKS = 4
) (
    // Clock, reset and register port
    input wire logic              MCLK_I,
    input wire logic              RESETN_I,
    input wire logic [FCR_AW-1:0] ADDR_I,
    input wire logic [FCR_DW-1:0] WDATA_I,
    input wire logic              WR_I,
    input wire logic              RD_I,
    input wire logic [FCR_DW-1:0] RDATA_O,
    // Context, errors and decisions
    input wire fcr_exec_t         EXEC_I,
    input wire fcr_err_t          ERR_I,
    input wire fcr_dec_t          DEC_O,
    input wire logic [FCR_DW-1:0] FEATURE_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);
    wire logic [FCR_DW-1:0] f = FEATURE_O;
    fcr_page_t              pg;
    logic                   virt;
    ////////////////////////////////////////////////////////////////////////
    // Expected decisions from the same cycle's image
    always_comb begin
        pg = FCR_PG_4K;
        if (f[FCR_B_WIDE] && EXEC_I.large_page_select) pg = FCR_PG_2M;
        if (!f[FCR_B_WIDE] && f[FCR_B_4MPG] && EXEC_I.large_page_select)
            pg = FCR_PG_4M;
    end
    assign virt = (f[FCR_B_V86] & EXEC_I.v86_mode) | (f[FCR_B_PVI] &
        !EXEC_I.v86_mode & (EXEC_I.prot_mode | EXEC_I.long_mode));
    ////////////////////////////////////////////////////////////////////////
    rd_idle_a: assert property (!$past(RD_I) |-> RDATA_O == '0)
        else $error("read data outside its slot");
    rsv_zero_a: assert property ((f & ~FCR_FC_WMASK) == '0)
        else $error("reserved feature bit set");
    wr_feat_a: assert property (WR_I && ADDR_I == FCR_OFF_FC |=>
        f == ($past(WDATA_I) & FCR_FC_WMASK)) else $error("write lost");
    ts_fault_a: assert property (1 |=> DEC_O.ts_fault ==
        $past(EXEC_I.tsc_instr && f[FCR_B_TSR] && EXEC_I.cpl != 2'h0))
        else $error("timestamp fault wrong");
    pmc_fault_a: assert property (1 |=> DEC_O.pmc_fault ==
        $past(EXEC_I.pmc_instr && !f[FCR_B_PMCU] && EXEC_I.cpl != 2'h0))
        else $error("counter fault wrong");
    dbg_ud_a: assert property (EXEC_I.dbg_acc &&
        f[FCR_B_IOBP] && EXEC_I.dbg_idx inside {3'h4, 3'h5}
        |=> DEC_O.dbg_ud && !DEC_O.dbg_go)
        else $error("debug fault missing");
    dbg_alias_a: assert property (EXEC_I.dbg_acc &&
        !f[FCR_B_IOBP] && EXEC_I.dbg_idx inside {3'h4, 3'h5}
        |=> DEC_O.dbg_go && !DEC_O.dbg_ud
        && DEC_O.dbg_idx == $past(EXEC_I.dbg_idx) + 3'h2)
        else $error("debug alias wrong");
    dbg_plain_a: assert property (EXEC_I.dbg_acc &&
        !(EXEC_I.dbg_idx inside {3'h4, 3'h5}) |=> DEC_O.dbg_go
        && !DEC_O.dbg_ud && DEC_O.dbg_idx == $past(EXEC_I.dbg_idx))
        else $error("debug pass wrong");
    dbg_idle_a: assert property (!EXEC_I.dbg_acc |=>
        !DEC_O.dbg_go && !DEC_O.dbg_ud) else $error("debug stray");
    page_sel_a: assert property (1 |=>
        DEC_O.page_size == $past(pg)) else $error("page size wrong");
    wide_ent_a: assert property (1 |=>
        DEC_O.wide_entry == $past(f[FCR_B_WIDE]) && DEC_O.long_mode_bad ==
        $past(EXEC_I.long_mode && !f[FCR_B_WIDE])) else $error("wide wrong");
    virt_int_a: assert property (1 |=>
        DEC_O.sti_cli_virt == $past(virt) && DEC_O.tss_redirect ==
        $past(f[FCR_B_V86] && EXEC_I.v86_mode) && DEC_O.v86_virt_int ==
        $past(f[FCR_B_V86] && EXEC_I.v86_mode))
        else $error("virtual interrupt wrong");
    no_mc_a: assert property (!(ERR_I.valid
        && ERR_I.uncorr && f[FCR_B_MCHK]) |=> !DEC_O.mc_fault)
        else $error("stray fault");
    simd_ud_a: assert property (1 |=> DEC_O.sse_ud ==
        $past(EXEC_I.sse_instr && !f[FCR_B_SRS]) && DEC_O.simd_ud ==
        $past(EXEC_I.simd_fp_exc && !f[FCR_B_SIMD])) else $error("simd wrong");
    glob_keep_a: assert property (1 |=> DEC_O.keep_global ==
        $past(EXEC_I.tbase_write && f[FCR_B_GPG])) else $error("global wrong");
    dec_misc_a: assert property (1 |=>
        DEC_O.io_bp_en == $past(f[FCR_B_IOBP]) && DEC_O.simd_xf ==
        $past(EXEC_I.simd_fp_exc && f[FCR_B_SIMD]) && DEC_O.tlb_flush ==
        $past(EXEC_I.tbase_write)) else $error("decision field wrong");
    cover property (DEC_O.mc_fault);
    cover property (DEC_O.dbg_ud);
    cover property (DEC_O.ts_fault);
    cover property (DEC_O.page_size == FCR_PG_2M);
endmodule // fcr_top_chk
bind fcr_top fcr_top_chk #(.NUM_BANKS(NUM_BANKS)) u_chk (.MCLK_I(MCLK_I),
    .RESETN_I(RESETN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .EXEC_I(EXEC_I), .ERR_I(ERR_I),
    .DEC_O(DEC_O), .FEATURE_O(FEATURE_O));

// [tb/fcr_top_tb.sv]
// Self-checking bench for the feature control register
`timescale 1ns/100ps
module fcr_top_tb
    import fcr_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [FCR_AW-1:0] adr = '0;
    logic [FCR_DW-1:0] wd = '0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic              rd_d = 1'b0;
    logic [FCR_DW-1:0] rdata, feat, d;
    logic [31:0]       r, code;
    fcr_exec_t         ex = '0;
    fcr_err_t          er = '0;
    fcr_dec_t          dec;
    logic [FCR_DW-1:0] q[$];
    int                errors = 0;
    int                num_checks = 0;
    fcr_top uut (.MCLK_I(clk), .RESETN_I(rst_n), .ADDR_I(adr), .WDATA_I(wd),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .EXEC_I(ex), .ERR_I(er),
        .DEC_O(dec), .FEATURE_O(feat));
    initial begin
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wrt(input logic [7:0] a, input logic [63:0] v);
        @(posedge clk);
        adr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Expected read data waits in the queue until its slot
    task automatic rdx(input logic [7:0] a, input logic [63:0] e);
        @(posedge clk);
        adr <= a;
        rd <= 1'b1;
        q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    task automatic mc(input logic u, input logic [3:0] b, input logic f);
        @(posedge clk);
        er <= '{1'b1, u, b, code};
        @(posedge clk);
        er.valid <= 1'b0;
        #1 check(dec.mc_fault, f);
    endtask
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) check(rdata, q.pop_front());
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        r = $urandom(32'h34B1E61E);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        #1 check(feat, FCR_FC_RESET);
        rdx(FCR_OFF_FC, FCR_FC_RESET);
        rdx(8'hF0, '0);
        for (int i = 0; i < 24; i++) begin
            d = {$urandom, $urandom};
            ex.legacy_mode <= d[40];
            wrt(FCR_OFF_FC, d);
            #1 check(feat, d & FCR_FC_WMASK);
            rdx(FCR_OFF_FC, d & FCR_FC_WMASK);
        end
        // Random context and errors; the checker judges the decisions
        wrt(8'h20, 64'h1);
        for (int i = 0; i < 16; i++) begin
            wrt(FCR_OFF_FC, {$urandom, $urandom});
            repeat (30) begin
                @(posedge clk);
                r = $urandom;
                ex <= r[15:0];
                er <= {r[31:26], $urandom};
            end
        end
        @(posedge clk);
        ex <= '0;
        er <= '0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1 check(feat, FCR_FC_RESET);
        rdx(8'h28, FCR_STS_RESET);
        wrt(FCR_OFF_FC, 64'h40);
        wrt(8'h20, 64'h1);
        rdx(8'h20, 64'h1);
        code = $urandom;
        mc(1'b1, 4'h0, 1'b1);
        rdx(8'h28, {2'h3, 30'h0, code});
        mc(1'b0, 4'h0, 1'b0);
        rdx(8'h28, {2'h2, 30'h0, code});
        mc(1'b1, 4'h1, 1'b0);
        rdx(8'h38, '0);
        wrt(FCR_OFF_FC, 64'h0);
        mc(1'b1, 4'h0, 1'b0);
        rdx(8'h28, {2'h3, 30'h0, code});
        wrt(8'h28, 64'h5);
        rdx(8'h28, '0);
        repeat (3) @(posedge clk);
        give_verdict();
    end
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
endmodule // fcr_top_tb
